// ---- logic/tkcal_top.sv ----
`timescale 1ns/1ps
// Behaviour
// R01: each channel has own variance and baseline
// R02: above baseline plus variance: touch, baseline kept
// R03: between variance and env band: no touch, hold
// R04: inside env band above baseline: track upward
// R05: below baseline: load sample as baseline
// R06: compare on 127 minus readout values
// R07: seven-bit impedance, 128 steps of 40 fF
// R08: calibrate only after quiet wait on all channels
// R09: repeat calibrations every recalibration period
// R10: reference delay shifts reference up to 5.1pF
// R11: count raw touches per integration period
// R12: filtered touch needs count above threshold
// R13: mode 1 reports strongest channel only
// R14: mode 2 reports all above threshold
// R15: mode 3 reports two strongest channels
// R16: host picks mode, reads touch byte
// R17: reset enters active state at once
// R18: idle time sleeps, touch in sleep wakes
// R19: sleep calibrates only with sleep bit set
// R20: host may order deep power down
// R21: sleep or power down waits for release
// R22: each pin is touch input or GPIO
// R23: host reaches settings over I2C slave 0x58; here settings are plain input ports, the slave is outside
// R24: evaluate per measurement, equality takes lower case
module tkcal_top
    import tkcal_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC,
    parameter int IDLE_CYCLES = IDLE_CYC
) (
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    // Measurement front end
    input  wire logic                  meas_valid,
    input  wire logic [1:0]            meas_chan,
    input  wire tkcal_imp_t            meas_imp,
    output tkcal_imp_t                 ref_delay_out,
    // Calibration settings
    input  wire tkcal_imp_t [NCH-1:0]  touch_var,
    input  wire tkcal_imp_t            env_var,
    input  wire tkcal_imp_t            ref_delay,
    input  wire tkcal_cnt_t            etc_wait,
    input  wire tkcal_cnt_t            recalibration_period,
    input  wire logic                  sleep_calibrate_bit,
    // Filter settings
    input  wire tkcal_cnt_t            integration_time,
    input  wire tkcal_cnt_t            hit_count_threshold,
    input  wire tkcal_mode_e           filter_mode_select,
    // Power commands
    input  wire logic                  sleep_cmd,
    input  wire logic                  deep_power_down_cmd,
    input  wire logic                  wake_cmd,
    // Pin mux
    input  wire logic [NCH-1:0]        touch_mode,
    input  wire logic [NCH-1:0]        gpio_dir,
    input  wire logic [NCH-1:0]        gpio_out,
    input  wire logic [NCH-1:0]        pad_in,
    output logic [NCH-1:0]             pad_out,
    output logic [NCH-1:0]             pad_oe_n,
    output logic [NCH-1:0]             gpio_in,
    // Results
    output logic [NCH-1:0]             raw_touch,
    output tkcal_imp_t [NCH-1:0]       calibrated_imp,
    output tkcal_cnt_t [NCH-1:0]       hit_count,
    output tkcal_cnt_t                 touch_byte,
    output tkcal_pwr_e                 power_state
);
    tkcal_flt_if flt_bus ();

    tkcal_filter u_filter (
        .f (flt_bus.flt)
    );

    tkcal_imp_t [NCH-1:0] base_ff;
    tkcal_imp_t [NCH-1:0] cal_rd_ff;
    tkcal_cnt_t [NCH-1:0] acc_ff;
    tkcal_cnt_t [NCH-1:0] hit_count_ff;
    logic [NCH-1:0]       raw_touch_ff;
    logic [NCH-1:0]       cal_pend_ff;
    logic [NCH-1:0]       pad_s1_ff;
    logic [NCH-1:0]       pad_s2_ff;
    logic [NCH-1:0]       pad_s3_ff;
    logic [NCH-1:0]       gpio_in_ff;
    logic [NCH-1:0]       pad_out_ff;
    logic [NCH-1:0]       pad_oe_n_ff;
    tkcal_imp_t           ref_delay_ff;
    tkcal_cnt_t           touch_byte_ff;
    tkcal_cnt_t           quiet_cnt_ff;
    tkcal_cnt_t           ival_cnt_ff;
    tkcal_cnt_t           integ_cnt_ff;
    logic [31:0]          tick_cnt_ff;
    logic                 tick_ff;
    logic [31:0]          idle_cnt_ff;
    logic                 sleep_pend_ff;
    logic                 deep_pend_ff;
    tkcal_pwr_e           pwr_ff;
    tkcal_pwr_e           nxt_pwr;

    logic       chan_ok;
    logic [1:0] sel;
    logic       meas_ok;
    tkcal_imp_t w_imp;
    tkcal_imp_t w_base;
    logic [7:0] sum_tv;
    logic [7:0] sum_ev;
    logic       w_hit;
    logic       w_hold;
    logic       w_track;
    logic       w_drop;
    logic       cal_ok;
    logic       quiet;
    logic       cal_fire;
    logic       integ_end;
    logic       held;

    function automatic tkcal_cnt_t sat_inc(input tkcal_cnt_t v, input logic inc);
        return (inc && v != CNT_MAX) ? v + 8'h01 : v;
    endfunction

    // Settings come from the host register port; the serial slave is outside
    assign flt_bus.hit_count           = hit_count_ff; // R23
    assign flt_bus.hit_count_threshold = hit_count_threshold;
    assign flt_bus.filter_mode_select  = filter_mode_select; // R16

    // Classification of one finished measurement
    always_comb begin
        chan_ok = meas_chan <= CH_LAST;
        sel     = chan_ok ? meas_chan : 2'h0;
        meas_ok = meas_valid && chan_ok && touch_mode[sel]
                  && pwr_ff != PS_DEEP_POWER_DOWN; // R24 R22
        w_imp   = inv_imp(meas_imp); // R06 R07
        w_base  = base_ff[sel]; // R01
        sum_tv  = {1'b0, w_base} + {1'b0, touch_var[sel]};
        sum_ev  = {1'b0, w_base} + {1'b0, env_var};
        w_hit   = {1'b0, w_imp} > sum_tv; // R02 R24
        w_hold  = !w_hit && {1'b0, w_imp} > sum_ev; // R03
        w_track = !w_hit && !w_hold && w_imp > w_base; // R04
        w_drop  = w_imp < w_base; // R05
        cal_ok  = pwr_ff == PS_ACTIVE
                  || (pwr_ff == PS_SLEEP && sleep_calibrate_bit); // R19
        quiet   = raw_touch_ff == '0 && quiet_cnt_ff == etc_wait;
        cal_fire  = quiet && tick_ff && ival_cnt_ff == 8'h00;
        integ_end = tick_ff && integ_cnt_ff >= integration_time;
        held      = raw_touch_ff != '0 || touch_byte_ff != 8'h00;
    end

    // Baseline per channel
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            base_ff <= {NCH{BASE_RST}};
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (meas_ok && sel == 2'(i) && cal_ok
                    && (w_drop || (w_track && cal_pend_ff[i]))) begin
                    base_ff[i] <= w_imp; // R04 R05 R08
                end
            end
        end
    end

    // Readout form trails the working baseline by one cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cal_rd_ff <= {NCH{IMP_FULL - BASE_RST}};
        end else begin
            for (int i = 0; i < NCH; i++) begin
                cal_rd_ff[i] <= inv_imp(base_ff[i]); // R06
            end
        end
    end

    // Raw touch state, refreshed on each measurement of a channel
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            raw_touch_ff <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (!touch_mode[i] || pwr_ff == PS_DEEP_POWER_DOWN) begin
                    raw_touch_ff[i] <= 1'b0; // R22
                end else if (meas_ok && sel == 2'(i)) begin
                    raw_touch_ff[i] <= w_hit; // R02
                end
            end
        end
    end

    // Time base for all programmable periods
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_ff <= 32'h0;
            tick_ff     <= 1'b0;
        end else begin
            tick_ff     <= tick_cnt_ff == 32'(TICK_CYCLES - 1);
            tick_cnt_ff <= (tick_cnt_ff == 32'(TICK_CYCLES - 1)) ? 32'h0 : tick_cnt_ff + 32'h1;
        end
    end

    // Quiet wait on all channels, then periodic calibration permits
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            quiet_cnt_ff <= 8'h00;
            ival_cnt_ff  <= 8'h00;
        end else begin
            if (raw_touch_ff != '0) begin
                quiet_cnt_ff <= 8'h00; // R08
            end else if (tick_ff && quiet_cnt_ff < etc_wait) begin
                quiet_cnt_ff <= quiet_cnt_ff + 8'h01;
            end else if (quiet_cnt_ff > etc_wait) begin
                quiet_cnt_ff <= etc_wait;
            end
            if (!quiet) begin
                ival_cnt_ff <= 8'h00;
            end else if (cal_fire) begin
                ival_cnt_ff <= recalibration_period; // R09
            end else if (tick_ff) begin
                ival_cnt_ff <= ival_cnt_ff - 8'h01;
            end
        end
    end

    // A permit is spent by one tracking update; a new permit wins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cal_pend_ff <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (cal_fire) begin
                    cal_pend_ff[i] <= 1'b1; // R09
                end else if (raw_touch_ff != '0) begin
                    cal_pend_ff[i] <= 1'b0; // R08
                end else if (meas_ok && sel == 2'(i) && w_track && cal_ok) begin
                    cal_pend_ff[i] <= 1'b0;
                end
            end
        end
    end

    // Hit integration over the programmed period
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_ff       <= '0;
            hit_count_ff <= '0;
            integ_cnt_ff <= 8'h00;
        end else begin
            integ_cnt_ff <= integ_end ? 8'h00 : integ_cnt_ff + {7'h00, tick_ff};
            for (int i = 0; i < NCH; i++) begin
                if (integ_end) begin
                    hit_count_ff[i] <= sat_inc(acc_ff[i], meas_ok && sel == 2'(i) && w_hit); // R11
                    acc_ff[i]       <= 8'h00;
                end else begin
                    acc_ff[i] <= sat_inc(acc_ff[i], meas_ok && sel == 2'(i) && w_hit); // R11
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            touch_byte_ff <= 8'h00;
        end else begin
            touch_byte_ff <= {5'h00, flt_bus.pick}; // R16
        end
    end

    // Power commands wait while a key is held; a new command wins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_pend_ff <= 1'b0;
            deep_pend_ff  <= 1'b0;
        end else begin
            sleep_pend_ff <= sleep_cmd
                             || (sleep_pend_ff && !wake_cmd && pwr_ff == PS_ACTIVE && held); // R21
            deep_pend_ff  <= deep_power_down_cmd
                             || (deep_pend_ff && !wake_cmd && pwr_ff != PS_DEEP_POWER_DOWN
                                 && held); // R20 R21
        end
    end

    always_comb begin
        nxt_pwr = pwr_ff;
        unique case (pwr_ff)
            PS_ACTIVE: begin
                if (deep_pend_ff && !held) begin
                    nxt_pwr = PS_DEEP_POWER_DOWN; // R21
                end else if (!held
                             && (sleep_pend_ff || idle_cnt_ff == 32'(IDLE_CYCLES - 1))) begin
                    // A touch measured in the last idle cycle does not block sleep; it wakes the part next cycle
                    nxt_pwr = PS_SLEEP; // R18
                end
            end
            PS_SLEEP: begin
                if (raw_touch_ff != '0) begin
                    nxt_pwr = PS_ACTIVE; // R18
                end else if (deep_pend_ff) begin
                    nxt_pwr = PS_DEEP_POWER_DOWN; // R20
                end
            end
            PS_DEEP_POWER_DOWN: begin
                if (wake_cmd) begin
                    nxt_pwr = PS_ACTIVE;
                end
            end
            default: nxt_pwr = PS_ACTIVE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_ff <= PS_ACTIVE; // R17
        end else begin
            pwr_ff <= nxt_pwr;
        end
    end

    // Inactivity timer runs only in active state
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_cnt_ff <= 32'h0;
        end else if (held || pwr_ff != PS_ACTIVE || nxt_pwr != PS_ACTIVE) begin
            idle_cnt_ff <= 32'h0;
        end else begin
            idle_cnt_ff <= idle_cnt_ff + 32'h1; // R18
        end
    end

    // Pin mux; input change accepted once stages two and three agree
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pad_s1_ff    <= '0;
            pad_s2_ff    <= '0;
            pad_s3_ff    <= '0;
            gpio_in_ff   <= '0;
            pad_out_ff   <= '0;
            pad_oe_n_ff  <= '1;
            ref_delay_ff <= 7'h00;
        end else begin
            pad_s1_ff    <= pad_in;
            pad_s2_ff    <= pad_s1_ff;
            pad_s3_ff    <= pad_s2_ff;
            for (int i = 0; i < NCH; i++) begin
                if (pad_s2_ff[i] == pad_s3_ff[i]) begin
                    gpio_in_ff[i] <= pad_s3_ff[i];
                end
            end
            pad_out_ff   <= gpio_out & ~touch_mode; // R22
            pad_oe_n_ff  <= ~(gpio_dir & ~touch_mode); // R22
            ref_delay_ff <= ref_delay; // R10
        end
    end

    assign ref_delay_out  = ref_delay_ff;
    assign pad_out        = pad_out_ff;
    assign pad_oe_n       = pad_oe_n_ff;
    assign gpio_in        = gpio_in_ff;
    assign raw_touch      = raw_touch_ff;
    assign calibrated_imp = cal_rd_ff;
    assign hit_count      = hit_count_ff;
    assign touch_byte     = touch_byte_ff;
    assign power_state    = pwr_ff;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_quiet_fire;
        quiet && tick_ff && ival_cnt_ff == 8'h00;
    endsequence

    sequence s_touch_seen;
        meas_ok && w_hit && sel == 2'h0;
    endsequence

    chk_touch_reported: assert property (s_touch_seen |=> raw_touch_ff[0]) // R02
        else $error("touch on channel 0 not reported");
    chk_touch_base_kept: assert property (meas_ok && w_hit |=> $stable(base_ff)) // R02
        else $error("baseline moved on touch");
    chk_hold_band: assert property (meas_ok && w_hold |=> $stable(base_ff)) // R03
        else $error("baseline moved in hold band");
    chk_drop_load: assert property ( // R05
        meas_ok && w_drop && cal_ok && sel == 2'h1 |=> base_ff[1] == $past(w_imp))
        else $error("low sample not loaded as baseline");
    chk_track_gated: assert property ( // R08
        meas_ok && w_track && !cal_pend_ff[sel] |=> $stable(base_ff))
        else $error("tracking without permit");
    chk_recal_fire: assert property ( // R09
        s_quiet_fire ##0 raw_touch_ff == '0
        |=> cal_pend_ff == '1 && ival_cnt_ff == $past(recalibration_period))
        else $error("calibration permit not issued");
    chk_thr_strict: assert property ( // R12
        flt_bus.pick[0] |-> hit_count_ff[0] > hit_count_threshold)
        else $error("touch at or below threshold");
    chk_top1_single: assert property ( // R13
        filter_mode_select == FLT_TOP1 |-> $onehot0(flt_bus.pick))
        else $error("mode 1 reports several channels");
    chk_top2_pair: assert property ( // R15
        filter_mode_select == FLT_TOP2 |-> !(&flt_bus.pick))
        else $error("mode 3 reports three channels");
    chk_sleep_nocal: assert property ( // R19
        pwr_ff == PS_SLEEP && !sleep_calibrate_bit |=> $stable(base_ff))
        else $error("calibration while asleep without bit");
    chk_sleep_wake: assert property ( // R18
        pwr_ff == PS_SLEEP && raw_touch_ff != '0 |=> pwr_ff == PS_ACTIVE)
        else $error("touch in sleep did not wake");
    chk_held_defer: assert property ( // R21
        pwr_ff == PS_ACTIVE && held |=> pwr_ff == PS_ACTIVE)
        else $error("power command taken while key held");
endmodule // tkcal_top

// ---- include/tkcal_pkg.sv ----
package tkcal_pkg;
    localparam int         NCH        = 3;
    localparam logic [1:0] CH_LAST    = 2'h2;
    // Quantiser: 128 steps of 40 fF give a 7-bit impedance
    localparam int         CAP_STEPS   = 128;
    localparam int         CAP_STEP_FF = 40;
    localparam logic [6:0] IMP_FULL    = 7'h7F;
    // Reference shift span of the delay setting, in fF
    localparam int         REF_SHIFT_MAX_FF = 5100;
    // Working baseline after reset: highest, so the first sample loads it
    localparam logic [6:0] BASE_RST    = 7'h7F;
    localparam logic [7:0] CNT_MAX     = 8'hFF;
    // Timing
    localparam int CLK_MHZ  = 250;
    localparam int TICK_US  = 1000;
    localparam int TICK_CYC = TICK_US * CLK_MHZ;
    localparam int IDLE_US  = 100000;
    localparam int IDLE_CYC = IDLE_US * CLK_MHZ;

    typedef logic [6:0] tkcal_imp_t;
    typedef logic [7:0] tkcal_cnt_t;

    typedef enum logic [1:0] {
        FLT_PLAIN = 2'h0,
        FLT_TOP1  = 2'h1,
        FLT_ALL   = 2'h2,
        FLT_TOP2  = 2'h3
    } tkcal_mode_e;

    typedef enum logic [1:0] {
        PS_ACTIVE          = 2'h0,
        PS_SLEEP           = 2'h1,
        PS_DEEP_POWER_DOWN = 2'h3
    } tkcal_pwr_e;

    // Host sees readout form, comparisons use the inverted form
    function automatic tkcal_imp_t inv_imp(input tkcal_imp_t v);
        return IMP_FULL - v;
    endfunction
endpackage

// ---- include/tkcal_flt_if.sv ----
`timescale 1ns/1ps
interface tkcal_flt_if;
    import tkcal_pkg::*;
    tkcal_cnt_t [NCH-1:0] hit_count;
    tkcal_cnt_t           hit_count_threshold;
    tkcal_mode_e          filter_mode_select;
    logic [NCH-1:0]       pick;
    modport core (output hit_count, hit_count_threshold, filter_mode_select, input pick);
    modport flt  (input hit_count, hit_count_threshold, filter_mode_select, output pick);
endinterface

// ---- logic/tkcal_filter.sv ----
`timescale 1ns/1ps
module tkcal_filter
    import tkcal_pkg::*;
(
    // Strengths in, selection out
    tkcal_flt_if.flt f
);
    // Ties go to the lower channel number
    function automatic logic [1:0] rank_of(input tkcal_cnt_t [NCH-1:0] s, input int i);
        logic [1:0] r;
        r = 2'h0;
        for (int j = 0; j < NCH; j++) begin
            if (j != i && (s[j] > s[i] || (s[j] == s[i] && j < i))) begin
                r = r + 2'h1;
            end
        end
        return r;
    endfunction

    always_comb begin
        logic       above;
        logic [1:0] rk;
        above = 1'b0;
        rk    = 2'h0;
        for (int i = 0; i < NCH; i++) begin
            above = f.hit_count[i] > f.hit_count_threshold; // R12
            rk    = rank_of(f.hit_count, i);
            unique case (f.filter_mode_select)
                FLT_TOP1: f.pick[i] = above && rk == 2'h0; // R13
                FLT_TOP2: f.pick[i] = above && rk <= 2'h1; // R15
                FLT_ALL,
                FLT_PLAIN: f.pick[i] = above; // R14
            endcase
        end
    end
endmodule // tkcal_filter

// ---- verif/tkcal_fe_model.sv ----
`timescale 1ns/1ps
// Measurement front end: single shots on request, or a fixed touch pattern
module tkcal_fe_model
    import tkcal_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // Control from the bench
    input  wire logic       req,
    input  wire logic [1:0] req_chan,
    input  wire tkcal_imp_t req_imp,
    input  wire logic       stream,
    // Measurement port
    output logic            meas_valid,
    output logic [1:0]      meas_chan,
    output tkcal_imp_t      meas_imp
);
    logic [2:0] step_ff;

    // Pattern 0,1,0,2,0,1 gives hit ratios 3:2:1 whatever the period phase
    function automatic logic [1:0] pat(input logic [2:0] s);
        case (s)
            3'h1, 3'h5: return 2'h1;
            3'h3:       return 2'h2;
            default:    return 2'h0;
        endcase
    endfunction

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meas_valid <= 1'b0;
            meas_chan  <= 2'h0;
            meas_imp   <= 7'h00;
            step_ff    <= 3'h0;
        end else if (stream) begin
            meas_valid <= 1'b1;
            meas_chan  <= pat(step_ff);
            meas_imp   <= 7'h1B;
            step_ff    <= (step_ff == 3'h5) ? 3'h0 : step_ff + 3'h1;
        end else if (req) begin
            meas_valid <= 1'b1;
            meas_chan  <= req_chan;
            meas_imp   <= req_imp;
        end else begin
            // Idle bus carries junk so stale data is never mistaken for a sample
            meas_valid <= 1'b0;
            meas_chan  <= ~meas_chan;
            meas_imp   <= ~meas_imp;
        end
    end
endmodule // tkcal_fe_model

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb_top
    import tkcal_pkg::*;
;
    logic core_clk = 0, rst_n = 0, req = 0, stream = 0, meas_valid;
    logic [1:0] req_chan = 0, meas_chan;
    tkcal_imp_t req_imp = 0, meas_imp, env_var = 7'h03, ref_delay = 7'h15, ref_delay_out;
    tkcal_imp_t [NCH-1:0] touch_var = {3{7'h0A}}, calibrated_imp;
    tkcal_cnt_t etc_wait = 0, recal = 0, integ = 8'h02, thr = 8'hFF, touch_byte;
    tkcal_cnt_t [NCH-1:0] hit_count;
    tkcal_mode_e mode = FLT_ALL;
    tkcal_pwr_e power_state;
    logic sleep_bit = 1, sleep_cmd = 0, deep_cmd = 0, wake_cmd = 0;
    logic [NCH-1:0] touch_mode = 3'h7, gpio_dir = 0, gpio_out = 0, pad_in = 0;
    logic [NCH-1:0] pad_out, pad_oe_n, gpio_in, raw_touch;
    int fails = 0, n_checks = 0, cyc = 0;
    tkcal_mode_e mtab [5] = '{FLT_ALL, FLT_TOP1, FLT_TOP2, FLT_PLAIN, FLT_ALL};
    tkcal_cnt_t  ttab [5] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h04};
    tkcal_cnt_t  etab [5] = '{8'h07, 8'h01, 8'h03, 8'h07, 8'h01};

    initial begin
        forever #2 core_clk = ~core_clk;
    end

    tkcal_fe_model fe (.core_clk(core_clk), .rst_n(rst_n), .req(req), .req_chan(req_chan),
        .req_imp(req_imp), .stream(stream), .meas_valid(meas_valid), .meas_chan(meas_chan),
        .meas_imp(meas_imp));

    tkcal_top #(.TICK_CYCLES(4), .IDLE_CYCLES(50)) uut (.core_clk(core_clk), .rst_n(rst_n),
        .meas_valid(meas_valid), .meas_chan(meas_chan), .meas_imp(meas_imp),
        .ref_delay_out(ref_delay_out), .touch_var(touch_var), .env_var(env_var),
        .ref_delay(ref_delay), .etc_wait(etc_wait), .recalibration_period(recal),
        .sleep_calibrate_bit(sleep_bit), .integration_time(integ),
        .hit_count_threshold(thr), .filter_mode_select(mode), .sleep_cmd(sleep_cmd),
        .deep_power_down_cmd(deep_cmd), .wake_cmd(wake_cmd), .touch_mode(touch_mode),
        .gpio_dir(gpio_dir), .gpio_out(gpio_out), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe_n(pad_oe_n), .gpio_in(gpio_in), .raw_touch(raw_touch),
        .calibrated_imp(calibrated_imp), .hit_count(hit_count), .touch_byte(touch_byte),
        .power_state(power_state));

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // One measurement; results settle two edges after the request drops, and the task waits four
    task automatic meas(input logic [1:0] c, input tkcal_imp_t imp);
        @(posedge core_clk);
        req      <= 1'b1;
        req_chan <= c;
        req_imp  <= imp;
        @(posedge core_clk);
        req <= 1'b0;
        wait_cyc(4);
    endtask

    task automatic wait_ps(input tkcal_pwr_e e, input int n);
        for (int i = 0; i < n && power_state !== e; i++) begin
            wait_cyc(1);
        end
        `CHK("power_state", e, power_state)
    endtask

    task automatic pulse(input int which);
        @(posedge core_clk);
        sleep_cmd <= (which == 0);
        deep_cmd  <= (which == 1);
        wake_cmd  <= (which == 2);
        @(posedge core_clk);
        {sleep_cmd, deep_cmd, wake_cmd} <= 3'h0;
    endtask

    task automatic end_sim();
        if (fails == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Whole run needs several hundred cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            end_sim();
        end
    end

    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        wait_cyc(1);
        `CHK("power_state", PS_ACTIVE, power_state)
        meas(2'h0, 7'h4D);
        `CHK("cal0", 7'h4D, calibrated_imp[0])
        meas(2'h0, 7'h42);
        `CHK("raw0", 3'h1, raw_touch)
        `CHK("cal0", 7'h4D, calibrated_imp[0])
        meas(2'h0, 7'h43);
        `CHK("raw0", 3'h0, raw_touch)
        `CHK("cal0", 7'h4D, calibrated_imp[0])
        wait_cyc(12);
        meas(2'h0, 7'h4B);
        `CHK("cal0", 7'h4B, calibrated_imp[0])
        meas(2'h0, 7'h57);
        `CHK("cal0", 7'h57, calibrated_imp[0])
        meas(2'h1, 7'h64);
        meas(2'h2, 7'h64);
        `CHK("cal1", 7'h64, calibrated_imp[1])
        `CHK("cal0", 7'h57, calibrated_imp[0])
        @(posedge core_clk);
        stream <= 1'b1;
        wait_cyc(40);
        `CHK("hits", {8'h02, 8'h04, 8'h06}, hit_count)
        for (int i = 0; i < 5; i++) begin
            @(posedge core_clk);
            mode <= mtab[i];
            thr  <= ttab[i];
            wait_cyc(16);
            `CHK("touch_byte", etab[i], touch_byte)
        end
        @(posedge core_clk);
        stream <= 1'b0;
        thr    <= 8'hFF;
        meas(2'h0, 7'h57);
        meas(2'h1, 7'h64);
        meas(2'h2, 7'h64);
        wait_ps(PS_SLEEP, 200);
        @(posedge core_clk);
        sleep_bit <= 1'b0;
        meas(2'h0, 7'h6B);
        `CHK("cal0", 7'h57, calibrated_imp[0])
        @(posedge core_clk);
        sleep_bit <= 1'b1;
        meas(2'h0, 7'h6B);
        `CHK("cal0", 7'h6B, calibrated_imp[0])
        meas(2'h0, 7'h1B);
        wait_ps(PS_ACTIVE, 8);
        pulse(0);
        wait_cyc(20);
        `CHK("power_state", PS_ACTIVE, power_state)
        meas(2'h0, 7'h6B);
        wait_ps(PS_SLEEP, 20);
        pulse(1);
        wait_ps(PS_DEEP_POWER_DOWN, 4);
        meas(2'h0, 7'h1B);
        `CHK("raw", 3'h0, raw_touch)
        pulse(2);
        wait_ps(PS_ACTIVE, 4);
        // Quiet wait of 8 ticks, then permits every 11 ticks
        @(posedge core_clk);
        etc_wait <= 8'h08;
        recal    <= 8'h0A;
        meas(2'h0, 7'h1B);
        meas(2'h0, 7'h6A);
        meas(2'h0, 7'h6A);
        `CHK("cal0", 7'h6B, calibrated_imp[0])
        wait_cyc(40);
        meas(2'h0, 7'h6A);
        `CHK("cal0", 7'h6A, calibrated_imp[0])
        meas(2'h0, 7'h69);
        `CHK("cal0", 7'h6A, calibrated_imp[0])
        wait_cyc(40);
        meas(2'h0, 7'h69);
        `CHK("cal0", 7'h69, calibrated_imp[0])
        `CHK("ref_delay_out", 7'h15, ref_delay_out)
        @(posedge core_clk);
        touch_mode <= 3'h1;
        gpio_dir   <= 3'h4;
        gpio_out   <= 3'h4;
        pad_in     <= 3'h2;
        wait_cyc(8);
        `CHK("pad_oe_n", 3'h3, pad_oe_n)
        `CHK("pad_out", 3'h4, pad_out)
        `CHK("gpio_in1", 1'b1, gpio_in[1])
        end_sim();
    end
endmodule // tb_top
